// ### pkg/linkmap_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the link
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef LINKMAP_DEFINES_SVH
`define LINKMAP_DEFINES_SVH
// Device register offsets
`define A_APP_MODE   16'h0200
`define A_DECIM      16'h0201
`define A_OUT_FMT    16'h0561
`define A_LANE_RATE  16'h056E
`define A_PLL_STAT   16'h056F
`define A_QUICK_CFG  16'h0570
`define A_PREEMPH_A  16'h05C4
`define A_PREEMPH_B  16'h05C6
`define A_TUNE_B     16'h1222
`define A_TUNE_A     16'h1228
`define A_TUNE_C     16'h1262
`define A_LINK_PWR   16'h0500
// Field positions
`define F_PLL_LOCK   7
`define F_RATE_LOW   4
`define F_Q_IGNORE   5
`define F_FMT_OFFBIN 0
`define F_LINK_PDN   0
// Reset values
`define R_APP_MODE   8'h00
`define R_DECIM      8'h01
`define R_OUT_FMT    8'h00
`define R_LANE_RATE  8'h00
`define R_QUICK_CFG  8'h13
`define R_PREEMPH    8'h00
`define R_LINK_PWR   8'h00
`define R_TUNE       8'h00
// Written values
`define V_RATE_LOW   8'h10
`define V_RATE_HIGH  8'h00
`define V_TUNE_A1    8'h4F
`define V_TUNE_A2    8'h0F
`define V_TUNE_B1    8'h04
`define V_TUNE_B2    8'h00
`define V_TUNE_C1    8'h08
`define V_TUNE_C2    8'h00
`define V_PDN        8'h01
`define V_PUP        8'h00
// Application mode codes
`define MODE_FULL    4'h0
`define MODE_ONE_DDC 4'h1
`define MODE_TWO_DDC 4'h2
`define MODE_FOUR_DDC 4'h3
// Lane rate figures, in kbps, and 8b/10b ratio
`define RATE_MIN_KBPS 32'd1562500
`define RATE_MAX_KBPS 32'd15000000
`define RATE_LOW_KBPS 32'd6250000
`define CODE_NUM     32'd10
`define CODE_DEN     32'd8
// Link timing counts
`define SYNC_K_COUNT 3'd4
`define ILAS_LAST_MF 2'd3
// Host Wishbone offsets
`define WB_CTRL      8'h00
`define WB_QUICK     8'h04
`define WB_MODE      8'h08
`define WB_DECIM     8'h0C
`define WB_STATUS    8'h10
`define WB_RATE      8'h14
`endif

// ### pkg/linkmap_pkg.sv
// Purpose: Types and shared arithmetic of the converter link
// Assumes: linkmap_defines.svh on the include path
// Notes:   Lane rate arithmetic is shared by both ends
`include "linkmap_defines.svh"
package linkmap_pkg;
	typedef enum logic [1:0] {PH_CGS, PH_WAIT_LMFC, PH_ILAS, PH_DATA} phase_t;
	typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} host_st_t;
	typedef logic [7:0][15:0] vc_bank_t;

	// Lane rate in kbps from quick config, decimation and N'
	function automatic logic [31:0] lane_rate_kbps(
		input logic [7:0]  quick,
		input logic [7:0]  chip_decimation_ratio,
		input logic [4:0]  np,
		input logic [31:0] adc_khz);
		logic [31:0] m;
		logic [31:0] l;
		logic [31:0] d;
		m = 32'd1 << quick[4:3];
		l = 32'd1 << quick[7:6];
		d = (chip_decimation_ratio == 8'h00) ? 32'd1 : {24'd0, chip_decimation_ratio};
		return (m * {27'd0, np} * `CODE_NUM * adc_khz) / (`CODE_DEN * l * d);
	endfunction

	typedef struct packed {
		vc_bank_t    vc;
		logic [3:0]  count;
	} map_state_t;

	typedef struct packed {
		logic [7:0]  app_mode;
		logic [7:0]  decim;
		logic [7:0]  out_fmt;
		logic [7:0]  lane_rate;
		logic [6:0]  pll_spare;
		logic [7:0]  quick;
		logic [7:0]  pre_a;
		logic [7:0]  pre_b;
		logic [7:0]  tune_a;
		logic [7:0]  tune_b;
		logic [7:0]  tune_c;
		logic [7:0]  link_pwr;
		logic        ack;
		logic [7:0]  rdata;
		phase_t      phase;
		logic [7:0]  lmfc_cnt;
		logic [1:0]  ilas_mf;
		logic        mf_start;
		logic        frame_valid;
		logic [31:0] rate_kbps;
		logic        m_mismatch;
		logic        link_up;
	} dev_state_t;

	typedef struct packed {
		logic [7:0]  quick;
		logic [7:0]  mode;
		logic [7:0]  decim;
		host_st_t    st;
		logic [3:0]  step;
		logic        busy;
		logic        done;
		logic        err;
		logic        pll_locked;
		logic [31:0] rate_kbps;
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        sync_n;
		logic [2:0]  k_cnt;
		logic        wb_ack;
		logic [31:0] wb_dat;
		logic        link_up;
	} host_state_t;
endpackage

// ### pkg/linkmap_if.sv
// Purpose: Joins the converter end and the receiver end
// Assumes: One clock shared by both ends
// Notes:   Register port is a held request with a one-cycle ack
`timescale 1ns/10ps
`default_nettype none
interface linkmap_if;
	logic                  reg_req;     // Register request, held to ack
	logic                  reg_we;      // Request is a write
	logic [15:0]           reg_addr;    // Register offset
	logic [7:0]            reg_wdata;   // Write data
	logic [7:0]            reg_rdata;   // Read data, valid with ack
	logic                  reg_ack;     // One-cycle answer
	logic                  sync_n;      // Synchronisation request, low
	linkmap_pkg::phase_t   phase;       // Link phase of transmitter
	logic                  mf_start;    // Multiframe boundary pulse
	logic                  frame_valid; // User data frame present
	linkmap_pkg::vc_bank_t frame_data;  // Virtual converter samples
	logic [3:0]            vc_count;    // Virtual converters in use

	modport dev (input reg_req, reg_we, reg_addr, reg_wdata, sync_n,
		output reg_rdata, reg_ack, phase, mf_start, frame_valid,
		frame_data, vc_count);
	modport rx (output reg_req, reg_we, reg_addr, reg_wdata, sync_n,
		input reg_rdata, reg_ack, phase, mf_start, frame_valid,
		frame_data, vc_count);
endinterface
`default_nettype wire

// ### rtl/vc_mapper.sv
// Purpose: Maps ADC and downconverter streams onto virtual converters
// Assumes: Sample inputs are synchronous to mclk
// Notes:   Output bank and count are registered
`timescale 1ns/10ps
`default_nettype none
`include "linkmap_defines.svh"
module vc_mapper (
	input  wire logic                   mclk,     // Clock
	input  wire logic                   rst,      // Sync reset
	input  wire logic [3:0]             mode,     // Application mode
	input  wire logic                   q_ignore, // Real output only
	input  wire logic                   offbin,   // Offset binary output
	input  wire logic [15:0]            adc_ac,   // ADC A or C sample
	input  wire logic [15:0]            adc_bd,   // ADC B or D sample
	input  wire logic [3:0][15:0]       ddc_i,    // In-phase per block
	input  wire logic [3:0][15:0]       ddc_q,    // Quadrature per block
	output var  linkmap_pkg::vc_bank_t  vc,       // Mapped samples
	output var  logic [3:0]             count     // Converters in use
);
	linkmap_pkg::map_state_t q;
	linkmap_pkg::map_state_t d;
	logic [2:0]              nddc;

	// Two's complement unless offset binary chosen
	function automatic logic [15:0] fmt(input logic [15:0] s);
		return offbin ? {~s[15], s[14:0]} : s;
	endfunction

	// Mapping per mode
	always_comb begin
		d = '0;
		nddc = 3'd0;
		unique case (mode)
			`MODE_FULL: begin
				d.vc[0] = fmt(adc_ac);                  // [RQ17]
				d.vc[1] = fmt(adc_bd);                  // [RQ17]
				d.count = 4'd2;
			end
			`MODE_ONE_DDC:  nddc = 3'd1;
			`MODE_TWO_DDC:  nddc = 3'd2;                // [RQ16]
			`MODE_FOUR_DDC: nddc = 3'd4;                // [RQ7]
			default:        nddc = 3'd0;
		endcase
		for (int b = 0; b < 4; b++) begin
			if (3'(b) < nddc) begin
				if (q_ignore) begin
					d.vc[b] = fmt(ddc_i[b]);            // [RQ18]
				end else begin
					d.vc[2*b]   = fmt(ddc_i[b]);        // [RQ5]
					d.vc[2*b+1] = fmt(ddc_q[b]);        // [RQ5] [RQ6]
				end
			end
		end
		if (mode != `MODE_FULL) begin
			// Count of virtual, not physical, converters
			d.count = q_ignore ? {1'b0, nddc} : {nddc, 1'b0}; // [RQ8] [RQ11]
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign vc    = q.vc;
	assign count = q.count;
endmodule
`default_nettype wire

// ### rtl/conv_link_tx.sv
// Purpose: Converter end: registers, converter mapping, link phases
// Assumes: One frame per mclk cycle; receiver drives sync_n
// Notes:   Registers reached through the link register port
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "linkmap_defines.svh"
// Notes on behaviour
// RQ1: Samples two's complement unless format selects otherwise
// RQ2: PLL lock shown read-only at bit 7
// RQ3: Software sets lane rate bit 4 to match
// RQ4: Below 6.25 Gbps software writes 0x10 there
// RQ5: Complex pairs: I first converter, Q second
// RQ6: DDC I/Q counts like two real converters
// RQ7: Up to four DDC blocks, real or complex
// RQ8: Up to eight virtual converters
// RQ9: Six startup writes in fixed order
// RQ10: Quick config sets lanes, converters, octets
// RQ11: With DDCs, M counts virtual converters
// RQ12: Lane rate = M*N'*10/8*fout/L
// RQ13: Decimation ratio taken from its register
// RQ14: Power down, configure, then power up
// RQ15: Line rate kept within 1.5625-15 Gbps
// RQ16: Mode codes: 0 full, 1 one DDC, 2 two
// RQ17: Full mode: converters 0,1 carry ADC samples
// RQ18: Q-ignore bit 5 selects real output
// RQ19: Preemphasis disabled after reset
// RQ20: ILAS starts at next multiframe boundary after sync
module conv_link_tx #(
	parameter int          NP        = 16,     // Bits per sample, N'
	parameter logic [31:0] ADC_KHZ   = 32'd500000, // Converter clock
	parameter logic [7:0]  K_FRAMES  = 8'd32   // Frames per multiframe
) (
	input  wire logic                   mclk,         // Clock
	input  wire logic                   rst,          // Sync reset
	linkmap_if.dev                      link,         // Far end
	input  wire logic                   pll_lock,     // Serializer PLL lock
	input  wire logic [15:0]            adc_ac,       // ADC A or C sample
	input  wire logic [15:0]            adc_bd,       // ADC B or D sample
	input  wire logic [3:0][15:0]       ddc_i,        // DDC in-phase
	input  wire logic [3:0][15:0]       ddc_q,        // DDC quadrature
	output var  logic [31:0]            rate_kbps,    // Lane rate
	output var  logic                   m_mismatch,   // M differs from map, outside full mode
	output var  logic [1:0]             lanes_log2,   // Lane count, log2
	output var  logic [2:0]             octets_log2,  // Octets per frame, log2
	output var  logic                   preemph_on,   // Any preemphasis
	output var  logic                   link_up       // User data phase
);
	linkmap_pkg::dev_state_t q;
	linkmap_pkg::dev_state_t d;
	logic                    boundary;
	logic                    pdn;

	// Map streams from mode and Q-ignore
	vc_mapper u_map (
		.mclk     (mclk),
		.rst      (rst),
		.mode     (q.app_mode[3:0]),
		.q_ignore (q.app_mode[`F_Q_IGNORE]),
		.offbin   (q.out_fmt[`F_FMT_OFFBIN]),
		.adc_ac   (adc_ac),
		.adc_bd   (adc_bd),
		.ddc_i    (ddc_i),
		.ddc_q    (ddc_q),
		.vc       (link.frame_data),
		.count    (link.vc_count)
	);

	// Register read decode
	function automatic logic [7:0] rd_reg(input logic [15:0] a);
		unique case (a)
			`A_APP_MODE:  rd_reg = q.app_mode;
			`A_DECIM:     rd_reg = q.decim;
			`A_OUT_FMT:   rd_reg = q.out_fmt;
			`A_LANE_RATE: rd_reg = q.lane_rate;
			`A_PLL_STAT:  rd_reg = {pll_lock, q.pll_spare}; // [RQ2]
			`A_QUICK_CFG: rd_reg = q.quick;
			`A_PREEMPH_A: rd_reg = q.pre_a;
			`A_PREEMPH_B: rd_reg = q.pre_b;
			`A_TUNE_A:    rd_reg = q.tune_a;
			`A_TUNE_B:    rd_reg = q.tune_b;
			`A_TUNE_C:    rd_reg = q.tune_c;
			`A_LINK_PWR:  rd_reg = q.link_pwr;
			default:      rd_reg = 8'h00;
		endcase
	endfunction

	assign boundary = (q.lmfc_cnt == K_FRAMES - 8'd1);
	assign pdn      = q.link_pwr[`F_LINK_PDN];

	// Next state
	always_comb begin
		d = q;
		d.ack = 1'b0;
		// Register port: take a held request once, answer next cycle
		if (link.reg_req && !q.ack) begin
			d.ack   = 1'b1;
			d.rdata = rd_reg(link.reg_addr);
			if (link.reg_we) begin
				unique case (link.reg_addr)
					`A_APP_MODE:  d.app_mode  = link.reg_wdata; // [RQ16]
					`A_DECIM:     d.decim     = link.reg_wdata; // [RQ13]
					`A_OUT_FMT:   d.out_fmt   = link.reg_wdata; // [RQ1]
					`A_LANE_RATE: d.lane_rate = link.reg_wdata;
					`A_PLL_STAT:  d.pll_spare = link.reg_wdata[6:0]; // [RQ2]
					`A_QUICK_CFG: d.quick     = link.reg_wdata; // [RQ10]
					`A_PREEMPH_A: d.pre_a     = link.reg_wdata;
					`A_PREEMPH_B: d.pre_b     = link.reg_wdata;
					`A_TUNE_A:    d.tune_a    = link.reg_wdata;
					`A_TUNE_B:    d.tune_b    = link.reg_wdata;
					`A_TUNE_C:    d.tune_c    = link.reg_wdata;
					`A_LINK_PWR:  d.link_pwr  = link.reg_wdata;
					default:      d.rdata     = 8'h00;
				endcase
			end
		end
		// Lane rate from M, N', L and decimated sample rate
		d.rate_kbps = linkmap_pkg::lane_rate_kbps(q.quick, q.decim,
			5'(NP), ADC_KHZ);                               // [RQ12] [RQ13]
		// M must count virtual converters when DDCs are used
		d.m_mismatch = (q.app_mode[3:0] != `MODE_FULL) &&
			((4'd1 << q.quick[4:3]) != link.vc_count);      // [RQ11]
		// Local multiframe counter
		d.lmfc_cnt = boundary ? 8'h00 : q.lmfc_cnt + 8'd1;
		d.mf_start = boundary;
		// Link phases
		if (pdn || !link.sync_n) begin
			d.phase   = linkmap_pkg::PH_CGS;
			d.ilas_mf = 2'd0;
		end else begin
			unique case (q.phase)
				linkmap_pkg::PH_CGS:
					d.phase = linkmap_pkg::PH_WAIT_LMFC;
				linkmap_pkg::PH_WAIT_LMFC:
					if (boundary) begin
						d.phase   = linkmap_pkg::PH_ILAS;     // [RQ20]
						d.ilas_mf = 2'd0;
					end
				linkmap_pkg::PH_ILAS:
					if (boundary) begin
						if (q.ilas_mf == `ILAS_LAST_MF) begin
							d.phase = linkmap_pkg::PH_DATA;
						end else begin
							d.ilas_mf = q.ilas_mf + 2'd1;
						end
					end
				linkmap_pkg::PH_DATA:
					d.phase = linkmap_pkg::PH_DATA;
			endcase
		end
		d.frame_valid = (d.phase == linkmap_pkg::PH_DATA);
		d.link_up     = d.frame_valid;
	end

	// State register; preemphasis starts off
	always_ff @(posedge mclk) begin
		if (rst) begin
			q           <= '0;
			q.app_mode  <= `R_APP_MODE;
			q.decim     <= `R_DECIM;
			q.out_fmt   <= `R_OUT_FMT;                      // [RQ1]
			q.lane_rate <= `R_LANE_RATE;
			q.quick     <= `R_QUICK_CFG;
			q.pre_a     <= `R_PREEMPH;                      // [RQ19]
			q.pre_b     <= `R_PREEMPH;                      // [RQ19]
			q.tune_a    <= `R_TUNE;
			q.tune_b    <= `R_TUNE;
			q.tune_c    <= `R_TUNE;
			q.link_pwr  <= `R_LINK_PWR;
			q.phase     <= linkmap_pkg::PH_CGS;
		end else begin
			q <= d;
		end
	end

	// Outputs from registers
	assign link.reg_ack    = q.ack;
	assign link.reg_rdata  = q.rdata;
	assign link.phase      = q.phase;
	assign link.mf_start   = q.mf_start;
	assign link.frame_valid = q.frame_valid;
	assign rate_kbps       = q.rate_kbps;
	assign m_mismatch      = q.m_mismatch;
	assign lanes_log2      = q.quick[7:6];                  // [RQ10]
	assign octets_log2     = q.quick[2:0];                  // [RQ10]
	assign preemph_on      = |{q.pre_a, q.pre_b};
	assign link_up         = q.link_up;
endmodule
`default_nettype wire

// ### rtl/link_rx_ctrl.sv
// Purpose: Receiver end: configures the converter and syncs the link
// Assumes: Classic Wishbone slave on the user side
// Notes:   One go runs startup, power down, setup, power up, lock read
`timescale 1ns/10ps
`default_nettype none
`include "linkmap_defines.svh"
module link_rx_ctrl #(
	parameter int          NP      = 16,         // Bits per sample, N'
	parameter logic [31:0] ADC_KHZ = 32'd500000  // Converter clock
) (
	input  wire logic        mclk,     // Clock
	input  wire logic        rst,      // Sync reset
	linkmap_if.rx            link,     // Converter end
	input  wire logic        wb_cyc,   // Wishbone cycle
	input  wire logic        wb_stb,   // Wishbone strobe
	input  wire logic        wb_we,    // Wishbone write
	input  wire logic [7:0]  wb_adr,   // Wishbone byte address
	input  wire logic [3:0]  wb_sel,   // Wishbone byte enables
	input  wire logic [31:0] wb_dat_i, // Wishbone write data
	output var  logic [31:0] wb_dat_o, // Wishbone read data
	output var  logic        wb_ack,   // Wishbone ack
	output var  logic        link_up   // Receiving user data
);
	localparam logic [3:0] LAST_STEP = 4'd12;
	linkmap_pkg::host_state_t q;
	linkmap_pkg::host_state_t d;
	logic [31:0]              rate;
	logic [7:0]               rate_sel;

	// Sequence of register operations: {write, offset, data}
	function automatic logic [24:0] op(input logic [3:0] s);
		unique case (s)
			4'd0:  op = {1'b1, `A_TUNE_A, `V_TUNE_A1};    // [RQ9]
			4'd1:  op = {1'b1, `A_TUNE_A, `V_TUNE_A2};    // [RQ9]
			4'd2:  op = {1'b1, `A_TUNE_B, `V_TUNE_B1};    // [RQ9]
			4'd3:  op = {1'b1, `A_TUNE_B, `V_TUNE_B2};    // [RQ9]
			4'd4:  op = {1'b1, `A_TUNE_C, `V_TUNE_C1};    // [RQ9]
			4'd5:  op = {1'b1, `A_TUNE_C, `V_TUNE_C2};    // [RQ9]
			4'd6:  op = {1'b1, `A_LINK_PWR, `V_PDN};      // [RQ14]
			4'd7:  op = {1'b1, `A_QUICK_CFG, q.quick};    // [RQ14]
			4'd8:  op = {1'b1, `A_APP_MODE, q.mode};
			4'd9:  op = {1'b1, `A_DECIM, q.decim};
			4'd10: op = {1'b1, `A_LANE_RATE, rate_sel};   // [RQ3]
			4'd11: op = {1'b1, `A_LINK_PWR, `V_PUP};      // [RQ14]
			default: op = {1'b0, `A_PLL_STAT, 8'h00};
		endcase
	endfunction

	// Same lane rate figure as the converter end
	assign rate = linkmap_pkg::lane_rate_kbps(q.quick, q.decim, 5'(NP),
		ADC_KHZ);                                             // [RQ12]
	assign rate_sel = (rate < `RATE_LOW_KBPS) ? `V_RATE_LOW
		: `V_RATE_HIGH;                                       // [RQ4] [RQ3]

	// Next state
	always_comb begin
		d = q;
		d.wb_ack = 1'b0;
		d.rate_kbps = rate;
		// Wishbone slave, one wait state, unmapped reads zero
		if (wb_cyc && wb_stb && !q.wb_ack) begin
			d.wb_ack = 1'b1;
			d.wb_dat = 32'h0000_0000;
			unique case (wb_adr)
				`WB_CTRL:   d.wb_dat = {31'h0000_0000, q.busy};
				`WB_QUICK:  d.wb_dat = {24'h00_0000, q.quick};
				`WB_MODE:   d.wb_dat = {24'h00_0000, q.mode};
				`WB_DECIM:  d.wb_dat = {24'h00_0000, q.decim};
				`WB_STATUS: d.wb_dat = {27'h000_0000, q.link_up,
					q.pll_locked, q.err, q.done, q.busy};
				`WB_RATE:   d.wb_dat = q.rate_kbps;
				default:    d.wb_dat = 32'h0000_0000;
			endcase
			if (wb_we && wb_sel[0] && !q.busy) begin
				unique case (wb_adr)
					`WB_QUICK: d.quick = wb_dat_i[7:0];
					`WB_MODE:  d.mode  = wb_dat_i[7:0];
					`WB_DECIM: d.decim = wb_dat_i[7:0];
					`WB_CTRL:
						if (wb_dat_i[0]) begin
							d.done = 1'b0;
							// Refuse a configuration out of line-rate range
							if (rate < `RATE_MIN_KBPS ||
								rate > `RATE_MAX_KBPS) begin      // [RQ15]
								d.err = 1'b1;
							end else begin
								d.err  = 1'b0;
								d.busy = 1'b1;
								d.step = 4'd0;
								d.st   = linkmap_pkg::HS_ISSUE;
							end
						end
					default: d.busy = q.busy;
				endcase
			end
		end
		// Register sequencer toward the converter end
		unique case (q.st)
			linkmap_pkg::HS_IDLE: d.req = 1'b0;
			linkmap_pkg::HS_ISSUE: begin
				{d.we, d.addr, d.wdata} = op(q.step);
				d.req = 1'b1;
				d.st  = linkmap_pkg::HS_WAIT;
			end
			linkmap_pkg::HS_WAIT:
				if (link.reg_ack) begin
					d.req = 1'b0;
					if (q.step == LAST_STEP) begin
						d.pll_locked = link.reg_rdata[`F_PLL_LOCK]; // [RQ2]
						d.busy = 1'b0;
						d.done = 1'b1;
						d.st   = linkmap_pkg::HS_IDLE;
					end else begin
						d.step = q.step + 4'd1;
						d.st   = linkmap_pkg::HS_ISSUE;
					end
				end
		endcase
		// Hold sync low until four K frames seen after setup
		if (!q.done || link.phase != linkmap_pkg::PH_CGS && !q.sync_n &&
			q.k_cnt == 3'd0) begin
			d.k_cnt = 3'd0;
		end
		if (!q.done) begin
			d.sync_n = 1'b0;
		end else if (!q.sync_n) begin
			if (link.phase == linkmap_pkg::PH_CGS) begin
				d.k_cnt = q.k_cnt + 3'd1;
			end
			if (q.k_cnt == `SYNC_K_COUNT) begin
				d.sync_n = 1'b1;                                // [RQ20]
			end
		end
		d.link_up = link.frame_valid;
	end

	// State register
	always_ff @(posedge mclk) begin
		if (rst) begin
			q       <= '0;
			q.quick <= `R_QUICK_CFG;
			q.decim <= `R_DECIM;
			q.mode  <= 8'(`MODE_FULL);
			q.st    <= linkmap_pkg::HS_IDLE;
		end else begin
			q <= d;
		end
	end

	assign link.reg_req   = q.req;
	assign link.reg_we    = q.we;
	assign link.reg_addr  = q.addr;
	assign link.reg_wdata = q.wdata;
	assign link.sync_n    = q.sync_n;
	assign wb_dat_o       = q.wb_dat;
	assign wb_ack         = q.wb_ack;
	assign link_up        = q.link_up;
endmodule
`default_nettype wire

// ### bench/linkmap_chk.sv
// Purpose: Assertions on the link between the two ends
// Assumes: Signals taken straight from the joining interface
// Notes:   One clock domain with synchronous reset
`timescale 1ns/10ps
`default_nettype none
module linkmap_chk (
	input  wire logic                mclk,        // Clock
	input  wire logic                rst,         // Sync reset
	input  wire logic                reg_req,     // Register request
	input  wire logic                reg_we,      // Request is a write
	input  wire logic [15:0]         reg_addr,    // Register offset
	input  wire logic                reg_ack,     // One-cycle answer
	input  wire logic                sync_n,      // Sync request, low
	input  var  linkmap_pkg::phase_t phase,       // Transmitter phase
	input  wire logic                mf_start,    // Multiframe pulse
	input  wire logic                frame_valid, // User data present
	input  wire logic [3:0]          vc_count     // Converters in use
);
	logic [7:0] ilas_q;

	// Counts cycles spent in lane alignment, cleared elsewhere
	always_ff @(posedge mclk) begin
		if (rst || phase != linkmap_pkg::PH_ILAS)
			ilas_q <= 8'h00;
		else
			ilas_q <= ilas_q + 8'h01;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_ack_single: assert property (reg_ack |=> !reg_ack)
		else $error("register ack longer than one cycle");
	a_ack_answer: assert property (reg_req && !reg_ack |=> reg_ack)
		else $error("register request not answered next cycle");
	a_ack_cause: assert property (reg_ack |-> $past(reg_req))
		else $error("register ack without request");
	a_req_held: assert property (reg_req && !reg_ack |=>
		$stable(reg_addr) && $stable(reg_we))
		else $error("register request changed before ack");
	a_sync_drop: assert property (!sync_n |=>
		phase == linkmap_pkg::PH_CGS)
		else $error("link left code group phase under sync request");
	a_lmfc_wait: assert property (phase == linkmap_pkg::PH_WAIT_LMFC
		|-> ##[1:33] phase != linkmap_pkg::PH_WAIT_LMFC)
		else $error("no multiframe boundary while waiting");
	a_mf_period: assert property (mf_start |-> ##32 mf_start)
		else $error("multiframe period is not 32 frames");
	a_ilas_four: assert property (phase == linkmap_pkg::PH_DATA
		&& ilas_q != 8'h00 |-> ilas_q == 8'h80)
		else $error("alignment phase not four multiframes");
	a_valid_data: assert property (frame_valid |->
		phase == linkmap_pkg::PH_DATA)
		else $error("frame valid outside data phase");
	a_vc_limit: assert property (vc_count <= 4'h8)
		else $error("more than eight virtual converters");

	// Main scenarios reached
	c_reg_write: cover property (reg_ack && reg_we);
	c_ilas: cover property (phase == linkmap_pkg::PH_ILAS && mf_start);
	c_data: cover property ($rose(frame_valid));
endmodule
`default_nettype wire

// ### bench/serial_link_converter_mapping_tb.sv
// Purpose: Drives the receiver end over Wishbone and judges the link
// Assumes: Both ends at default parameters, N' 16, 500000 kHz
// Notes:   Register writes on the link are logged for order checks
`timescale 1ns/10ps
`default_nettype none
`include "linkmap_defines.svh"
module serial_link_converter_mapping_tb;
	logic             mclk, rst, pll_lock, wb_cyc, wb_stb, wb_we, wb_ack;
	logic             rx_up, dev_up, m_mis, pre_on;
	logic [1:0]       lanes;
	logic [2:0]       octs;
	logic [7:0]       wb_adr;
	logic [15:0]      adc_ac, adc_bd;
	logic [31:0]      wb_dat_i, wb_dat_o, rate, rd;
	logic [3:0][15:0] ddc_i, ddc_q;
	logic [23:0]      wlog[$];
	int               bad_count, checks, cyc_n;
	linkmap_if        lnk();

	conv_link_tx u_conv_link_tx (.mclk(mclk), .rst(rst), .link(lnk.dev),
		.pll_lock(pll_lock), .adc_ac(adc_ac), .adc_bd(adc_bd),
		.ddc_i(ddc_i), .ddc_q(ddc_q), .rate_kbps(rate), .m_mismatch(m_mis),
		.lanes_log2(lanes), .octets_log2(octs), .preemph_on(pre_on),
		.link_up(dev_up));
	link_rx_ctrl u_link_rx_ctrl (.mclk(mclk), .rst(rst), .link(lnk.rx),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack(wb_ack), .link_up(rx_up));
	linkmap_chk u_linkmap_chk (.mclk(mclk), .rst(rst),
		.reg_req(lnk.reg_req), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
		.reg_ack(lnk.reg_ack), .sync_n(lnk.sync_n), .phase(lnk.phase),
		.mf_start(lnk.mf_start), .frame_valid(lnk.frame_valid),
		.vc_count(lnk.vc_count));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Classic single Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= w;
		wb_adr   <= a;
		wb_dat_i <= d;
		@(posedge mclk);
		while (wb_ack !== 1'b1) @(posedge mclk);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge mclk);
	endtask

	// Sets quick, mode and decimation, starts a pass, polls until idle
	task automatic run(input logic [7:0] q, m, dv);
		wb(1'b1, `WB_QUICK, {24'h00_0000, q});
		wb(1'b1, `WB_MODE, {24'h00_0000, m});
		wb(1'b1, `WB_DECIM, {24'h00_0000, dv});
		wlog.delete();
		wb(1'b1, `WB_CTRL, 32'h0000_0001);
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) wb(1'b0, `WB_STATUS, 32'h0000_0000);
	endtask

	task automatic t_reset();
		wb(1'b0, `WB_QUICK, 32'h0000_0000);
		chk(rd, 32'h0000_0013);
		wb(1'b0, `WB_DECIM, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		wb(1'b0, 8'h1C, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(32'(pre_on), 32'h0000_0000);
	endtask

	// Full pass with write order, lane rate figures and link bring-up
	task automatic t_link(input logic [7:0] q, input logic [7:0] lr);
		logic [23:0] ex [6] = '{24'h12_284F, 24'h12_280F, 24'h12_2204,
			24'h12_2200, 24'h12_6208, 24'h12_6200};
		longint r;
		r = (64'd1 << q[4:3]) * 16 * 10 * 500000 / (8 * (64'd1 << q[7:6]) * 4);
		run(q, 8'h02, 8'h04);
		chk(32'(rd[3:1]), 32'h0000_0005);
		for (int k = 0; k < 6; k++) chk(32'(wlog[k]), 32'(ex[k]));
		chk(32'(wlog[6]), 32'h0005_0001);
		chk(32'(wlog[7]), {8'h00, 16'h0570, q});
		chk(32'(wlog[10]), {8'h00, 16'h056E, lr});
		chk(32'(wlog[11]), 32'h0005_0000);
		chk(rate, 32'(r));
		chk(32'(lanes), 32'(q[7:6]));
		chk(32'(octs), 32'(q[2:0]));
		while (rx_up !== 1'b1) @(posedge mclk);
		chk(32'(dev_up), 32'h0000_0001);
		chk(32'(lnk.frame_valid), 32'h0000_0001);
	endtask

	// Every application mode, real and complex
	task automatic t_modes();
		logic [7:0] md [7] = '{8'h00, 8'h21, 8'h01, 8'h22, 8'h02, 8'h23, 8'h03};
		logic [3:0] cn [7] = '{4'h2, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8};
		logic [15:0] e1;
		for (int k = 0; k < 7; k++) begin
			run(8'h13, md[k], 8'h04);
			e1 = (k == 0) ? adc_bd : (md[k][5] ? ddc_i[1] : ddc_q[0]);
			chk(32'(lnk.vc_count), 32'(cn[k]));
			chk(32'(lnk.frame_data[0]), 32'((k == 0) ? adc_ac : ddc_i[0]));
			if (cn[k] > 4'h1) chk(32'(lnk.frame_data[1]), 32'(e1));
			if (k > 0) chk(32'(m_mis), 32'(cn[k] != 4'h4));
		end
		chk(32'(lnk.frame_data[7]), 32'(ddc_q[3]));
	endtask

	// Out-of-range rate and an unlocked serializer
	task automatic t_err();
		pll_lock <= 1'b0;
		run(8'h13, 8'h02, 8'hFF);
		chk(32'(rd[2]), 32'h0000_0001);
		run(8'h13, 8'h02, 8'h04);
		chk(32'(rd[3]), 32'h0000_0000);
		pll_lock <= 1'b1;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Logs link writes and cuts a hang short
	always @(posedge mclk) begin
		if (lnk.reg_ack === 1'b1 && lnk.reg_we === 1'b1)
			wlog.push_back({lnk.reg_addr, lnk.reg_wdata});
		cyc_n++;
		if (cyc_n == 8000) begin
			bad_count++;
			end_sim();
		end
	end

	// Main sequence
	initial begin
		{rst, pll_lock, wb_cyc, wb_stb, wb_we} = 5'h18;
		wb_adr = 8'h00;
		wb_dat_i = 32'h0000_0000;
		adc_ac = 16'h1A01;
		adc_bd = 16'h1B02;
		ddc_i = {16'h2003, 16'h2002, 16'h2001, 16'h2000};
		ddc_q = {16'h3003, 16'h3002, 16'h3001, 16'h3000};
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_link(8'h13, 8'h00);
		t_link(8'h52, 8'h10);
		t_modes();
		t_err();
		end_sim();
	end
endmodule
`default_nettype wire
